// *** ess_pkg.sv ***
// Purpose: Shared constants, codes and carrier types of the emergency stop sequencer
// Assumes: 250 MHz control clock, speed in units of 0.01 rpm, delay in units of 1 ms
// Notes:   Every offset-free setting of the block is a plain port; codes live here
package ess_pkg;

  // Clock and delay timebase
  localparam int CLK_PERIOD_NS  = 4;
  localparam int DELAY_UNIT_NS  = 1000000;
  // Least time, so round up to whole cycles
  localparam int CYCLES_PER_MS  = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Field widths
  localparam int SPEED_W        = 22;       // Up to 30000.00 rpm in 0.01 rpm steps
  localparam int DELAY_W        = 15;       // Up to 30000 ms
  localparam int NUM_DI         = 4;
  localparam int DELAY_MAX_MS   = 30000;

  // Suggested zero speed limit: 30.00 rpm
  localparam logic [SPEED_W-1:0] ZERO_LIMIT_DEFAULT = 22'h000BB8;

  // Stop style codes; reset default is the normal ramp stop
  typedef enum logic [1:0] {
    ESS_NORMAL_RAMP_STOP    = 2'h0,
    ESS_COAST_STOP          = 2'h1,
    ESS_EMERGENCY_RAMP_STOP = 2'h2
  } ess_style_t;

  // Emergency stop source codes
  localparam logic [2:0] SRC_CONST_LOW  = 3'h0;
  localparam logic [2:0] SRC_CONST_HIGH = 3'h1;
  localparam logic [2:0] SRC_DI_FIRST   = 3'h3;
  localparam logic [2:0] SRC_DI_LAST    = 3'h6;
  localparam logic [2:0] SRC_DEFAULT    = SRC_CONST_HIGH;

  // Enables toward the power stage and speed controller
  typedef struct packed {
    logic modulationEnable;
    logic speedCtrlEnable;
    logic magnetizeEnable;
    logic rampDown;
    logic emergencyRamp;
  } ess_drive_t;

  localparam ess_drive_t DRIVE_OFF = '0;

endpackage : ess_pkg

// *** ess_src_sel.sv ***
// Purpose: Synchronises pin inputs and selects the emergency stop signal
// Assumes: Digital inputs and start pin are asynchronous to mclk
// Notes:   Unused source codes resolve to an active stop, the safe side
`timescale 1ns/1ps
module ess_src_sel #(
  parameter int NUM_DI = ess_pkg::NUM_DI
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [NUM_DI-1:0] digitalInputs,
  input  wire logic              startPin,
  input  wire logic [2:0]        srcSel,
  output logic                   estopSig,
  output logic                   startSync
);

  logic [NUM_DI-1:0] diMeta_q;
  logic [NUM_DI-1:0] diSync_q;
  logic              startMeta_q;
  logic              startSync_q;
  logic [2:0]        diOffset;

  // Source codes fix the input count at four
  if (NUM_DI != 4) begin : g_bad_num_di
    $error("ess_src_sel: NUM_DI must be 4");
  end

  // Two-stage synchronisers; first stage feeds only the second
  // Start stages reset high so a start held through reset makes no edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      diMeta_q    <= '0;
      diSync_q    <= '0;
      startMeta_q <= 1'b1;
      startSync_q <= 1'b1;
    end else begin
      diMeta_q    <= digitalInputs;
      diSync_q    <= diMeta_q;
      startMeta_q <= startPin;
      startSync_q <= startMeta_q;
    end
  end

  // Source multiplexer, low means stop requested
  always_comb begin
    diOffset  = srcSel - ess_pkg::SRC_DI_FIRST;
    startSync = startSync_q;
    if (srcSel == ess_pkg::SRC_CONST_LOW) begin
      estopSig = 1'b0;
    end else if (srcSel == ess_pkg::SRC_CONST_HIGH) begin
      estopSig = 1'b1;
    end else if (srcSel >= ess_pkg::SRC_DI_FIRST && srcSel <= ess_pkg::SRC_DI_LAST) begin
      estopSig = diSync_q[diOffset[1:0]];
    end else begin
      estopSig = 1'b0;                  // Reserved codes stop the drive
    end
  end

endmodule : ess_src_sel

// *** ess_ms_timer.sv ***
// Purpose: Zero speed delay timer counting whole milliseconds
// Assumes: load is a one-cycle pulse with a nonzero delay
// Notes:   Dropping run abandons the count at once
`timescale 1ns/1ps
module ess_ms_timer #(
  parameter int CYCLES_PER_MS = ess_pkg::CYCLES_PER_MS,
  parameter int DELAY_W       = ess_pkg::DELAY_W
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               load,
  input  wire logic               run,
  input  wire logic [DELAY_W-1:0] delayMs,
  output logic                    expired
);

  localparam int TICK_W = $clog2(CYCLES_PER_MS + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_MS - 1);

  logic [TICK_W-1:0]  tick_q;
  logic [TICK_W-1:0]  tick_d;
  logic [DELAY_W-1:0] msLeft_q;
  logic [DELAY_W-1:0] msLeft_d;
  logic               expired_q;
  logic               expired_d;

  if (CYCLES_PER_MS < 1) begin : g_bad_cycles
    $error("ess_ms_timer: CYCLES_PER_MS must be at least 1");
  end

  // Tick divider and millisecond down-counter
  always_comb begin
    tick_d    = tick_q;
    msLeft_d  = msLeft_q;
    expired_d = 1'b0;
    if (load) begin
      tick_d   = '0;
      msLeft_d = delayMs;
    end else if (!run) begin
      tick_d   = '0;
      msLeft_d = '0;
    end else if (msLeft_q != '0) begin
      if (tick_q == TICK_LAST) begin
        tick_d   = '0;
        msLeft_d = msLeft_q - 1'b1;
        if (msLeft_q == DELAY_W'(1)) expired_d = 1'b1;
      end else begin
        tick_d = tick_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_q    <= '0;
      msLeft_q  <= '0;
      expired_q <= 1'b0;
    end else begin
      tick_q    <= tick_d;
      msLeft_q  <= msLeft_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

endmodule : ess_ms_timer

// *** ess_sequencer.sv ***
// Purpose: Emergency stop sequencer for a motor drive
// Assumes: speedMeasured is an unsigned magnitude on mclk; ramp generator lives outside
// Notes:   Outputs are registered from the next state, so they change on the same edge as the state
`timescale 1ns/1ps
module ess_sequencer #(
  parameter int CYCLES_PER_MS = ess_pkg::CYCLES_PER_MS
) (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         startPin,
  input  wire logic [ess_pkg::NUM_DI-1:0]   digitalInputs,
  input  wire logic [1:0]                   stopStyle,
  input  wire logic [2:0]                   stopSource,
  input  wire logic [ess_pkg::SPEED_W-1:0]  speedMeasured,
  input  wire logic [ess_pkg::SPEED_W-1:0]  zeroSpeedLimit,
  input  wire logic [ess_pkg::DELAY_W-1:0]  zeroSpeedDelayMs,
  output ess_pkg::ess_drive_t               drive,
  output logic                              running,
  output logic                              startBlocked,
  output logic [2:0]                        activeSource
);

  typedef enum logic [1:0] {
    ST_STOPPED,
    ST_RUN,
    ST_RAMP,
    ST_ZERO_DELAY
  } ess_state_t;

  ess_state_t          state_q;
  ess_state_t          state_d;
  logic [2:0]          srcSel_q;
  logic [2:0]          srcSel_d;
  logic                startPrev_q;
  logic                emeRamp_q;
  logic                emeRamp_d;
  ess_pkg::ess_drive_t drive_q;
  ess_pkg::ess_drive_t drive_d;
  logic                running_q;
  logic                startBlocked_q;
  logic                estopSig;
  logic                startSync;
  logic                startRise;
  logic                belowLimit;
  logic                coastNow;
  logic                timerLoad;
  logic                timerDone;

  // Synchronised pins and the selected stop signal
  ess_src_sel #(
    .NUM_DI        (ess_pkg::NUM_DI)
  ) u_src_sel (
    .mclk          (mclk),
    .rst           (rst),
    .digitalInputs (digitalInputs),
    .startPin      (startPin),
    .srcSel        (srcSel_q),
    .estopSig      (estopSig),
    .startSync     (startSync)
  );

  // Millisecond delay below the zero speed limit
  ess_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .DELAY_W       (ess_pkg::DELAY_W)
  ) u_ms_timer (
    .mclk          (mclk),
    .rst           (rst),
    .load          (timerLoad),
    .run           (state_q == ST_ZERO_DELAY),
    .delayMs       (zeroSpeedDelayMs),
    .expired       (timerDone)
  );

  // Event terms for the sequencer
  always_comb begin
    startRise  = startSync && !startPrev_q;
    belowLimit = speedMeasured < zeroSpeedLimit;
    coastNow   = !estopSig && (stopStyle == ess_pkg::ESS_COAST_STOP);
    timerLoad  = (state_q == ST_RAMP) && (state_d == ST_ZERO_DELAY);
  end

  // Next state; a fresh start edge is needed from stopped
  always_comb begin
    state_d   = state_q;
    emeRamp_d = emeRamp_q;
    case (state_q)
      ST_STOPPED: begin
        // Stop signal checked with the edge, so an active stop wins
        if (startRise && estopSig) begin
          state_d   = ST_RUN;
          emeRamp_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (!estopSig) begin
          case (stopStyle)
            ess_pkg::ESS_COAST_STOP: begin
              state_d = ST_STOPPED;
            end
            ess_pkg::ESS_EMERGENCY_RAMP_STOP: begin
              state_d   = ST_RAMP;
              emeRamp_d = 1'b1;
            end
            default: begin
              state_d   = ST_RAMP;
              emeRamp_d = 1'b0;
            end
          endcase
        end else if (!startSync) begin
          state_d   = ST_RAMP;                                    // Plain stop command
          emeRamp_d = 1'b0;
        end
      end
      ST_RAMP: begin
        if (coastNow) begin
          state_d = ST_STOPPED;
        end else if (belowLimit) begin
          if (zeroSpeedDelayMs == '0) begin
            state_d = ST_STOPPED;
          end else begin
            state_d = ST_ZERO_DELAY;
          end
        end
      end
      ST_ZERO_DELAY: begin
        if (timerDone || coastNow) begin
          state_d = ST_STOPPED;
        end else if (startRise && estopSig) begin
          state_d   = ST_RUN;                                     // Quick restart
          emeRamp_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_STOPPED;
      end
    endcase
  end

  // Output enables follow the next state
  always_comb begin
    drive_d  = ess_pkg::DRIVE_OFF;
    // Not taken on the start edge either, so a run never sees a new source
    srcSel_d = (state_q == ST_STOPPED && state_d == ST_STOPPED) ? stopSource : srcSel_q;
    case (state_d)
      ST_RUN: begin
        drive_d.modulationEnable = 1'b1;
        drive_d.speedCtrlEnable  = 1'b1;
        drive_d.magnetizeEnable  = 1'b1;
      end
      ST_RAMP: begin
        drive_d.modulationEnable = 1'b1;
        drive_d.speedCtrlEnable  = 1'b1;
        drive_d.magnetizeEnable  = 1'b1;
        drive_d.rampDown         = 1'b1;
        drive_d.emergencyRamp    = emeRamp_d;
      end
      ST_ZERO_DELAY: begin
        // Control kept live so a restart needs no magnetising
        drive_d.modulationEnable = 1'b1;
        drive_d.speedCtrlEnable  = 1'b1;
        drive_d.magnetizeEnable  = 1'b1;
      end
      default: begin
        drive_d = ess_pkg::DRIVE_OFF;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q        <= ST_STOPPED;
      srcSel_q       <= ess_pkg::SRC_DEFAULT;
      startPrev_q    <= 1'b1;                                     // Start held at reset needs a new edge
      emeRamp_q      <= 1'b0;
      drive_q        <= ess_pkg::DRIVE_OFF;
      running_q      <= 1'b0;
      startBlocked_q <= 1'b1;
    end else begin
      state_q        <= state_d;
      srcSel_q       <= srcSel_d;
      startPrev_q    <= startSync;
      emeRamp_q      <= emeRamp_d;
      drive_q        <= drive_d;
      running_q      <= state_d != ST_STOPPED;
      startBlocked_q <= (state_d == ST_STOPPED) && !estopSig;
    end
  end

  assign drive        = drive_q;
  assign running      = running_q;
  assign startBlocked = startBlocked_q;
  assign activeSource = srcSel_q;

  // Checks
  sequence sRunStopLow;
    state_q == ST_RUN && !estopSig;
  endsequence

  sequence sRampAtLimit;
    state_q == ST_RAMP && !coastNow && belowLimit;
  endsequence

  sequence sEnteredDelay;
    state_q == ST_RAMP ##1 state_q == ST_ZERO_DELAY;
  endsequence

  coast_cut_a: assert property (@(posedge mclk) disable iff (rst)
    sRunStopLow and (stopStyle == ess_pkg::ESS_COAST_STOP)
      |=> !drive.modulationEnable && state_q == ST_STOPPED)
    else $error("coast stop did not cut modulation");

  normal_ramp_a: assert property (@(posedge mclk) disable iff (rst)
    sRunStopLow and (stopStyle == ess_pkg::ESS_NORMAL_RAMP_STOP)
      |=> drive.rampDown && !drive.emergencyRamp && drive.modulationEnable)
    else $error("normal ramp stop not requested");

  eme_ramp_a: assert property (@(posedge mclk) disable iff (rst)
    sRunStopLow and (stopStyle == ess_pkg::ESS_EMERGENCY_RAMP_STOP)
      |=> drive.rampDown && drive.emergencyRamp)
    else $error("emergency ramp not selected");

  start_block_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_STOPPED && !estopSig |=> !running && startBlocked)
    else $error("start allowed while stop signal active");

  start_edge_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_STOPPED && estopSig && startSync && !startPrev_q |=> running && drive.modulationEnable)
    else $error("start edge did not restart");

  no_level_start_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_STOPPED && (startPrev_q || !estopSig) |=> state_q == ST_STOPPED)
    else $error("started without fresh edge or under stop");

  source_hold_a: assert property (@(posedge mclk) disable iff (rst)
    state_q != ST_STOPPED |=> $stable(activeSource))
    else $error("source changed while running");

  source_const_a: assert property (@(posedge mclk) disable iff (rst)
    activeSource == ess_pkg::SRC_CONST_LOW |-> !estopSig)
    else $error("constant low source not active");

  zero_cut_a: assert property (@(posedge mclk) disable iff (rst)
    sRampAtLimit and (zeroSpeedDelayMs == '0) |=> !drive.modulationEnable ##1 !drive.modulationEnable)
    else $error("modulation kept below limit without delay");

  delay_live_a: assert property (@(posedge mclk) disable iff (rst)
    sEnteredDelay |-> drive.modulationEnable && drive.speedCtrlEnable && drive.magnetizeEnable)
    else $error("control dropped during zero speed delay");

  delay_end_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_ZERO_DELAY && timerDone |=> !drive.modulationEnable && !running)
    else $error("modulation kept after delay expiry");

  sequence sCoastInStop;
    (state_q == ST_RAMP || state_q == ST_ZERO_DELAY) && coastNow;
  endsequence

  sequence sRestartInDelay;
    state_q == ST_ZERO_DELAY && !timerDone && !coastNow && startRise && estopSig;
  endsequence

  coast_late_a: assert property (@(posedge mclk) disable iff (rst)
    sCoastInStop |=> !drive.modulationEnable && !running)
    else $error("coast request ignored during ramp or delay");

  quick_restart_a: assert property (@(posedge mclk) disable iff (rst)
    sRestartInDelay |=> state_q == ST_RUN && drive.modulationEnable && !drive.rampDown)
    else $error("restart refused during zero speed delay");

  ramp_follow_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_RAMP && !coastNow && !belowLimit |=> drive.rampDown && drive.modulationEnable)
    else $error("ramp left above zero speed limit");

  run_hold_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_RUN && estopSig && startSync |=> state_q == ST_RUN && drive.modulationEnable)
    else $error("run dropped with stop signal high");

  start_allow_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_STOPPED && estopSig |=> !startBlocked)
    else $error("start blocked with stop signal high");

endmodule : ess_sequencer

// *** ess_speed_model.sv ***
// Purpose: Behavioural motor and speed feedback facing the stop sequencer
// Assumes: Speed in 0.01 rpm units, one update per mclk edge
// Notes:   Crude slopes; only the order of speed against the zero limit matters
`timescale 1ns/1ps
module ess_speed_model #(
  parameter int TOP_SPEED  = 5000,
  parameter int RISE_STEP  = 100,
  parameter int NORM_FALL  = 50,
  parameter int EMER_FALL  = 200,
  parameter int COAST_FALL = 10
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire ess_pkg::ess_drive_t           drive,
  output logic [ess_pkg::SPEED_W-1:0]        speed
);
  logic [ess_pkg::SPEED_W-1:0] speed_q;
  logic [ess_pkg::SPEED_W-1:0] speed_d;
  logic                        decel_q;
  logic                        decel_d;
  int                          step;

  // Next speed; after a ramp the controller brings the shaft to true zero
  always_comb begin
    speed_d = speed_q;
    decel_d = decel_q;
    step    = 0;
    if (!drive.modulationEnable) begin
      decel_d = 1'b0;
      step    = COAST_FALL; // Free coasting, slow decay
    end else if (drive.rampDown) begin
      decel_d = 1'b1;
      step    = drive.emergencyRamp ? EMER_FALL : NORM_FALL;
    end else if (decel_q) begin
      step    = NORM_FALL;
    end
    if (step != 0) begin
      speed_d = (int'(speed_q) > step) ? speed_q - ess_pkg::SPEED_W'(step) : '0;
    end else if (int'(speed_q) < TOP_SPEED) begin
      speed_d = speed_q + ess_pkg::SPEED_W'(RISE_STEP);
    end
  end

  // Registered shaft state
  always_ff @(posedge mclk) begin
    if (rst) begin
      speed_q <= '0;
      decel_q <= 1'b0;
    end else begin
      speed_q <= speed_d;
      decel_q <= decel_d;
    end
  end

  assign speed = speed_q;
endmodule : ess_speed_model

// *** tb_ess_sequencer.sv ***
// Purpose: Self-checking bench for the emergency stop sequencer
// Assumes: Shortened millisecond of 4 cycles; pins driven on rising edges
// Notes:   Speed feedback comes from a behavioural motor model
`timescale 1ns/1ps
module tb_ess_sequencer;
  localparam int CPM = 4;
  logic                         mclk;
  logic                         rst;
  logic                         startPin;
  logic [ess_pkg::NUM_DI-1:0]   digitalInputs;
  logic [1:0]                   stopStyle;
  logic [2:0]                   stopSource;
  logic [ess_pkg::SPEED_W-1:0]  speedMeasured;
  logic [ess_pkg::SPEED_W-1:0]  zeroLimit;
  logic [ess_pkg::DELAY_W-1:0]  zeroSpeedDelayMs;
  ess_pkg::ess_drive_t          drive;
  logic                         running;
  logic                         startBlocked;
  logic [2:0]                   activeSource;
  int                           errTotal;
  int                           testsRun;
  int                           n;

  ess_sequencer #(.CYCLES_PER_MS(CPM)) ess_sequencer_inst (
    .mclk(mclk), .rst(rst), .startPin(startPin), .digitalInputs(digitalInputs),
    .stopStyle(stopStyle), .stopSource(stopSource), .speedMeasured(speedMeasured),
    .zeroSpeedLimit(zeroLimit), .zeroSpeedDelayMs(zeroSpeedDelayMs), .drive(drive),
    .running(running), .startBlocked(startBlocked), .activeSource(activeSource)
  );

  ess_speed_model ess_speed_model_inst (.mclk(mclk), .rst(rst), .drive(drive), .speed(speedMeasured));

  // Free-running control clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks run %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Step past edges, then let their updates settle
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  // Bounded wait on running (0), modulation (1) or ramp down (2)
  task automatic wait_for(input int sel, input logic want, output int cyc);
    logic v;
    #1; // Never sample in the time step of a launching edge
    for (cyc = 0; cyc < 5000; cyc++) begin
      v = (sel == 0) ? running : (sel == 1) ? drive.modulationEnable : drive.rampDown;
      if (v === want) return;
      tick(1);
    end
    errTotal++;
    $display("MISMATCH t=%0t wait ran out", $time);
    wrap_up();
  endtask : wait_for

  // Fresh start edge: low long enough to pass the synchronisers, then high
  task automatic press_start;
    @(posedge mclk);
    startPin <= 1'b0;
    tick(3);
    @(posedge mclk);
    startPin <= 1'b1;
    tick(1);
  endtask : press_start

  initial begin
    rst = 1'b1;
    startPin = 1'b0;
    digitalInputs = '0;
    stopStyle = 2'h0;
    stopSource = ess_pkg::SRC_DEFAULT;
    zeroLimit = ess_pkg::ZERO_LIMIT_DEFAULT;
    zeroSpeedDelayMs = '0;
    errTotal = 0;
    testsRun = 0;
    tick(12);
    check(drive, ess_pkg::DRIVE_OFF);
    check(running, 1'b0);
    check(startBlocked, 1'b1);
    check(activeSource, 3'h1);
    @(posedge mclk);
    rst <= 1'b0;
    tick(3);
    // Constant low source with a start edge in the same cycle
    @(posedge mclk);
    stopSource <= ess_pkg::SRC_CONST_LOW;
    startPin <= 1'b1;
    tick(8);
    check(running, 1'b0);
    check(startBlocked, 1'b1);
    check(activeSource, 3'h0);
    // Constant high source lets the drive start
    @(posedge mclk);
    stopSource <= ess_pkg::SRC_CONST_HIGH;
    tick(3);
    check(startBlocked, 1'b0);
    press_start();
    wait_for(0, 1'b1, n);
    check(drive.modulationEnable, 1'b1);
    // Source change while running is ignored
    @(posedge mclk);
    stopSource <= ess_pkg::SRC_CONST_LOW;
    tick(5);
    check(activeSource, 3'h1);
    check(running, 1'b1);
    @(posedge mclk);
    startPin <= 1'b0;
    wait_for(0, 1'b0, n);
    // Each stop style on its own digital input; emergency ramp with a 2 ms delay
    for (int s = 0; s < 3; s++) begin
      @(posedge mclk);
      stopStyle <= 2'(s);
      stopSource <= 3'(3 + s);
      digitalInputs <= 4'hF;
      zeroSpeedDelayMs <= (s == 2) ? 15'h0002 : 15'h0000;
      tick(4);
      check(activeSource, 3 + s);
      press_start();
      wait_for(0, 1'b1, n);
      tick(80);
      @(posedge mclk);
      digitalInputs[s] <= 1'b0;
      if (s == 1) begin
        wait_for(1, 1'b0, n);
        check(n <= 5, 1'b1);
        check(drive, ess_pkg::DRIVE_OFF);
      end else begin
        wait_for(2, 1'b1, n);
        check(drive.emergencyRamp, s == 2);
        check(drive.modulationEnable, 1'b1);
        wait_for(2, 1'b0, n);
        check(speedMeasured < zeroLimit, 1'b1);
        check(drive.speedCtrlEnable & drive.magnetizeEnable, s == 2);
        wait_for(1, 1'b0, n);
        if (s == 0) check(n <= 2, 1'b1);
        else check(n >= 2 * CPM - 1 && n <= 2 * CPM + 3, 1'b1);
      end
      check(running, 1'b0);
      check(startBlocked, 1'b1);
      // Release with start still high: a level alone must not restart
      @(posedge mclk);
      digitalInputs <= 4'hF;
      tick(8);
      check(running, 1'b0);
    end
    // Fourth input held active blocks a fresh start edge
    @(posedge mclk);
    stopSource <= 3'h6;
    digitalInputs <= 4'h7;
    press_start();
    tick(8);
    check(running, 1'b0);
    check(startBlocked, 1'b1);
    check(activeSource, 3'h6);
    @(posedge mclk);
    digitalInputs <= 4'hF;
    tick(6);
    check(startBlocked, 1'b0);
    // Quick restart inside a 5 ms zero speed delay
    @(posedge mclk);
    zeroSpeedDelayMs <= 15'h0005;
    press_start();
    wait_for(0, 1'b1, n);
    tick(40);
    @(posedge mclk);
    startPin <= 1'b0;
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b0, n);
    check(drive.speedCtrlEnable, 1'b1);
    @(posedge mclk);
    startPin <= 1'b1;
    tick(8 * CPM);
    check(running, 1'b1);
    check(drive.modulationEnable, 1'b1);
    // Reset while running with start held: only a new edge may start
    @(posedge mclk);
    rst <= 1'b1;
    tick(3);
    check(drive, ess_pkg::DRIVE_OFF);
    check(activeSource, 3'h1);
    @(posedge mclk);
    rst <= 1'b0;
    tick(10);
    check(running, 1'b0);
    check(startBlocked, 1'b0);
    // Coast request arriving during a plain ramp stop
    press_start();
    wait_for(0, 1'b1, n);
    tick(40);
    @(posedge mclk);
    stopStyle <= 2'h1;
    startPin <= 1'b0;
    wait_for(2, 1'b1, n);
    @(posedge mclk);
    digitalInputs <= 4'h7;
    wait_for(1, 1'b0, n);
    check(n <= 5, 1'b1);
    check(running, 1'b0);
    // Reserved source code keeps the drive stopped
    @(posedge mclk);
    stopSource <= 3'h7;
    digitalInputs <= 4'hF;
    tick(4);
    check(startBlocked, 1'b1);
    wrap_up();
  end
endmodule : tb_ess_sequencer
